// File: hdl/pdam_alert_unit.sv
// alert aggregation: event flags, masks, summary bits and alert output
//
// Function
// - vbus high alarm sets low flag bit 7, held until host clears.
// - transmit success sets bit 6; transmit buffer is then empty.
// - transmit discarded by incoming receive sets bit 5; buffer empty.
// - no GoodCRC reply sets transmit-failed bit 4; buffer empty.
// - received hard reset sets low flag bit 3.
// - receive status change sets bit 2; zero byte count does not.
// - port power bit 1 set when power status AND mask nonzero.
// - cc status change sets low flag bit 0.
// - flags reset to zero; write one clears, write zero keeps.
// - vendor alert sets high flag bit 7.
// - vbus falling through sink disconnect threshold sets high bit 3.
// - overflow sets high bit 2; condition clears only via receive-status clear.
// - fault bit 1 set when fault status AND mask nonzero.
// - vbus low alarm sets high flag bit 0.
// - mask bit zero masks, one unmasks; positions match flags.
// - alert masks and power mask load all implemented bits to one on any reset (high mask 0x8f).
// - fault mask loads 0x33 on any reset.
// - power mask bits gate the eight power status conditions.
// - fault mask bits 7,5,4,1,0 writable; 6,3,2 read zero.
// - high mask writable at bits 7,3,2,1,0.
`default_nettype none
module pdam_alert_unit
  import pdam_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire pdam_req_s REG_REQ,
  output logic [7:0] REG_RDATA,
  input wire pdam_event_s EVENTS,
  input wire logic RX_BYTE_COUNT_ZERO,
  input wire logic SOFTWARE_RESET,
  input wire logic [7:0] POWER_STATUS,
  input wire logic [7:0] FAULT_STATUS,
  input wire logic [7:0] CC_STATUS,
  output logic TX_BUFFER_FLUSH,
  output logic RX_OVERFLOW_ACTIVE,
  output logic ALERT_N
);
  logic [7:0] flags_low_r;
  logic [7:0] flags_high_r;
  logic [7:0] mask_low_r;
  logic [7:0] mask_high_r;
  logic [7:0] power_mask_r;
  logic [7:0] fault_mask_r;
  logic overflow_r;
  logic [7:0] rdata_nxt;
  logic [7:0] set_low;
  logic [7:0] set_high;
  logic [7:0] clr_low;
  logic [7:0] clr_high;
  logic cc_changed;
  logic power_hit;
  logic fault_hit;
  logic soft_reset;
  logic alert_nxt;

  function automatic logic wr_hit(input pdam_req_s req, input logic [7:0] ofs);
    wr_hit = req.wr && (req.addr == ofs);
  endfunction

  pdam_change_det u_cc_det (
    .clk(CLK),
    .reset_n(RESET_N),
    .value(CC_STATUS),
    .changed(cc_changed)
  );

  // masks reload on software reset and on a received hard reset
  assign soft_reset = SOFTWARE_RESET || EVENTS.hard_reset_rx;

  assign power_hit = |(POWER_STATUS & power_mask_r);
  assign fault_hit = |(FAULT_STATUS & fault_mask_r);

  always_comb begin
    set_low = 8'h00;
    set_low[BIT_VBUS_HI] = EVENTS.vbus_high_alarm;
    set_low[BIT_TX_SUCC] = EVENTS.tx_success;
    set_low[BIT_TX_DISC] = EVENTS.tx_discarded;
    set_low[BIT_TX_FAIL] = EVENTS.tx_failed;
    set_low[BIT_HARD_RST] = EVENTS.hard_reset_rx;
    set_low[BIT_RX_STAT] = EVENTS.rx_status_change && !RX_BYTE_COUNT_ZERO;
    set_low[BIT_PORT_PWR] = power_hit;
    set_low[BIT_CC_CHG] = cc_changed;
    set_high = 8'h00;
    set_high[BIT_VENDOR] = EVENTS.vendor_alert;
    set_high[BIT_SNK_DISC] = EVENTS.sink_disconnect;
    set_high[BIT_RX_OVF] = EVENTS.rx_overflow;
    set_high[BIT_FAULT] = fault_hit;
    set_high[BIT_VBUS_LO] = EVENTS.vbus_low_alarm;
  end

  assign clr_low = wr_hit(REG_REQ, ALERT_FLAGS_LOW_OFS) ? REG_REQ.wdata : 8'h00;
  assign clr_high = wr_hit(REG_REQ, ALERT_FLAGS_HIGH_OFS) ? REG_REQ.wdata : 8'h00;

  // set wins over a clear in the same cycle, so no event is lost
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      flags_low_r <= ALERT_FLAGS_RST;
      flags_high_r <= ALERT_FLAGS_RST;
    end else begin
      flags_low_r <= (flags_low_r & ~clr_low) | set_low;
      flags_high_r <= ((flags_high_r & ~clr_high) | set_high) & FLAGS_HIGH_IMPL;
    end
  end

  // overflow condition outlives the acknowledge; only a receive-status clear ends it
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      overflow_r <= 1'b0;
    end else if (EVENTS.rx_overflow) begin
      overflow_r <= 1'b1;
    end else if (clr_low[BIT_RX_STAT]) begin
      overflow_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mask_low_r <= ALERT_MASK_RST;
      mask_high_r <= ALERT_MASK_RST & MASK_HIGH_IMPL;
      power_mask_r <= POWER_MASK_RST;
      fault_mask_r <= FAULT_MASK_RST;
    end else if (soft_reset) begin
      mask_low_r <= ALERT_MASK_RST;
      mask_high_r <= ALERT_MASK_RST & MASK_HIGH_IMPL;
      power_mask_r <= POWER_MASK_RST;
      fault_mask_r <= FAULT_MASK_RST;
    end else begin
      if (wr_hit(REG_REQ, ALERT_MASK_LOW_OFS)) begin
        mask_low_r <= REG_REQ.wdata;
      end
      if (wr_hit(REG_REQ, ALERT_MASK_HIGH_OFS)) begin
        mask_high_r <= REG_REQ.wdata & MASK_HIGH_IMPL;
      end
      if (wr_hit(REG_REQ, POWER_STATUS_MASK_OFS)) begin
        power_mask_r <= REG_REQ.wdata;
      end
      if (wr_hit(REG_REQ, FAULT_STATUS_MASK_OFS)) begin
        fault_mask_r <= REG_REQ.wdata & FAULT_MASK_IMPL;
      end
    end
  end

  always_comb begin
    case (REG_REQ.addr)
      ALERT_FLAGS_LOW_OFS: rdata_nxt = flags_low_r;
      ALERT_FLAGS_HIGH_OFS: rdata_nxt = flags_high_r;
      ALERT_MASK_LOW_OFS: rdata_nxt = mask_low_r;
      ALERT_MASK_HIGH_OFS: rdata_nxt = mask_high_r;
      POWER_STATUS_MASK_OFS: rdata_nxt = power_mask_r;
      FAULT_STATUS_MASK_OFS: rdata_nxt = fault_mask_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // alert uses registered state so the pin never glitches
  assign alert_nxt = |((flags_low_r & mask_low_r) |
                       (flags_high_r & mask_high_r));

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_RDATA <= 8'h00;
      ALERT_N <= 1'b1;
      TX_BUFFER_FLUSH <= 1'b0;
      RX_OVERFLOW_ACTIVE <= 1'b0;
    end else begin
      REG_RDATA <= rdata_nxt;
      ALERT_N <= ~alert_nxt;
      // any transmit outcome empties the transmit buffer
      TX_BUFFER_FLUSH <= EVENTS.tx_success | EVENTS.tx_discarded |
                         EVENTS.tx_failed;
      RX_OVERFLOW_ACTIVE <= overflow_r;
    end
  end
endmodule
`default_nettype wire

// File: pkg/pdam_pkg.sv
// package for the port alert mask unit: offsets, reset values, field layouts
`default_nettype none
package pdam_pkg;
  localparam logic [7:0] ALERT_FLAGS_LOW_OFS = 8'h10;
  localparam logic [7:0] ALERT_FLAGS_HIGH_OFS = 8'h11;
  localparam logic [7:0] ALERT_MASK_LOW_OFS = 8'h12;
  localparam logic [7:0] ALERT_MASK_HIGH_OFS = 8'h13;
  localparam logic [7:0] POWER_STATUS_MASK_OFS = 8'h14;
  localparam logic [7:0] FAULT_STATUS_MASK_OFS = 8'h15;

  localparam logic [7:0] ALERT_FLAGS_RST = 8'h00;
  localparam logic [7:0] ALERT_MASK_RST = 8'hff;
  localparam logic [7:0] POWER_MASK_RST = 8'hff;
  localparam logic [7:0] FAULT_MASK_RST = 8'h33;

  // writable bits of the mixed registers
  localparam logic [7:0] FLAGS_HIGH_IMPL = 8'h8f;
  localparam logic [7:0] MASK_HIGH_IMPL = 8'h8f;
  localparam logic [7:0] FAULT_MASK_IMPL = 8'hb3;

  // low flag bit positions
  localparam int BIT_VBUS_HI = 7;
  localparam int BIT_TX_SUCC = 6;
  localparam int BIT_TX_DISC = 5;
  localparam int BIT_TX_FAIL = 4;
  localparam int BIT_HARD_RST = 3;
  localparam int BIT_RX_STAT = 2;
  localparam int BIT_PORT_PWR = 1;
  localparam int BIT_CC_CHG = 0;
  // high flag bit positions
  localparam int BIT_VENDOR = 7;
  localparam int BIT_SNK_DISC = 3;
  localparam int BIT_RX_OVF = 2;
  localparam int BIT_FAULT = 1;
  localparam int BIT_VBUS_LO = 0;

  // one-cycle event strobes from the rest of the port controller
  typedef struct packed {
    logic vbus_high_alarm;
    logic tx_success;
    logic tx_discarded;
    logic tx_failed;
    logic hard_reset_rx;
    logic rx_status_change;
    logic vbus_low_alarm;
    logic vendor_alert;
    logic sink_disconnect;
    logic rx_overflow;
  } pdam_event_s;

  // register port request
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pdam_req_s;
endpackage
`default_nettype wire

// File: hdl/pdam_change_det.sv
// change detector: pulses when a status byte differs from its last value
`default_nettype none
module pdam_change_det
  import pdam_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] value,
  output logic changed
);
  logic [7:0] last_r;
  logic seen_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last_r <= 8'h00;
      seen_r <= 1'b0;
    end else begin
      last_r <= value;
      seen_r <= 1'b1;
    end
  end

  // first sample after reset is not a change
  assign changed = seen_r && (value != last_r);
endmodule
`default_nettype wire

// File: verif/pdam_alert_props.sv
// checker: port-level timing relations of the alert unit
`default_nettype none
module pdam_alert_props
  import pdam_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire pdam_req_s REG_REQ,
  input wire logic [7:0] REG_RDATA,
  input wire pdam_event_s EVENTS,
  input wire logic SOFTWARE_RESET,
  input wire logic TX_BUFFER_FLUSH,
  input wire logic RX_OVERFLOW_ACTIVE
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  logic w1_rx;
  assign w1_rx = REG_REQ.wr && REG_REQ.addr == ALERT_FLAGS_LOW_OFS && REG_REQ.wdata[2];
  sequence s_rd(logic [7:0] a);
    REG_REQ.addr == a && !REG_REQ.wr;
  endsequence
  sequence s_tx_done;
    EVENTS.tx_success || EVENTS.tx_discarded || EVENTS.tx_failed;
  endsequence
  a_flush_after_tx: assert property (
    s_tx_done |=> TX_BUFFER_FLUSH) else $error("no flush after tx outcome");
  // overflow output sits two flops behind its set and its clear
  a_ovf_sets: assert property (
    EVENTS.rx_overflow |-> ##2 RX_OVERFLOW_ACTIVE) else $error("overflow not raised");
  a_ovf_holds: assert property (
    RX_OVERFLOW_ACTIVE && !$past(w1_rx) |=> RX_OVERFLOW_ACTIVE)
    else $error("overflow dropped without clear");
  a_ovf_clears: assert property (
    w1_rx && !EVENTS.rx_overflow |-> ##2 !RX_OVERFLOW_ACTIVE)
    else $error("overflow kept after clear");
  a_high_rsvd: assert property (
    s_rd(ALERT_FLAGS_HIGH_OFS) or s_rd(ALERT_MASK_HIGH_OFS) |=> REG_RDATA[6:4] == 3'h0)
    else $error("reserved high bits nonzero");
  a_fault_rsvd: assert property (
    s_rd(FAULT_STATUS_MASK_OFS) |=> (REG_RDATA & 8'h4c) == 8'h00)
    else $error("reserved fault mask bits nonzero");
  a_flag_holds: assert property (
    s_rd(ALERT_FLAGS_LOW_OFS) [*2] ##0 REG_RDATA[7] |=> REG_RDATA[7])
    else $error("flag lost without write");
  a_hr_flag: assert property (
    EVENTS.hard_reset_rx ##1 s_rd(ALERT_FLAGS_LOW_OFS) |=> REG_RDATA[3])
    else $error("hard reset flag missing");
  a_sw_fault: assert property (
    SOFTWARE_RESET ##1 s_rd(FAULT_STATUS_MASK_OFS) |=> REG_RDATA == 8'h33)
    else $error("fault mask not reloaded");
endmodule
bind pdam_alert_unit pdam_alert_props u_pdam_alert_props(.CLK(CLK), .RESET_N(RESET_N),
  .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .EVENTS(EVENTS), .SOFTWARE_RESET(SOFTWARE_RESET),
  .TX_BUFFER_FLUSH(TX_BUFFER_FLUSH), .RX_OVERFLOW_ACTIVE(RX_OVERFLOW_ACTIVE));
`default_nettype wire

// File: verif/pdam_host_model.sv
// host model: register reads and writes on the request port
`default_nettype none
module pdam_host_model
  import pdam_pkg::*;
(
  input wire logic clk,
  output var pdam_req_s req,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req <= '{wr: 1'b1, addr: a, wdata: d};
    @(negedge clk);
    req.wr <= 1'b0;
  endtask
  // two edges so the answer reflects this address, not the last one
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    req.addr <= a;
    repeat (2) @(negedge clk);
    d = rdata;
  endtask
endmodule
`default_nettype wire

// File: verif/pd_port_alert_mask_unit_bench.sv
// self-checking bench for the alert unit
`default_nettype none
module pd_port_alert_mask_unit_bench
  import pdam_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic bcz = 1'b0;
  logic swr = 1'b0;
  logic ovf, alert_n;
  logic [7:0] rdata, pwr, flt, cc;
  pdam_req_s req;
  pdam_event_s ev;
  int num_errors = 0;
  int check_count = 0;
  always #2 clk = ~clk;
  pdam_alert_unit u_pdam_alert_unit(.CLK(clk), .RESET_N(reset_n), .REG_REQ(req),
    .REG_RDATA(rdata), .EVENTS(ev), .RX_BYTE_COUNT_ZERO(bcz), .SOFTWARE_RESET(swr),
    .POWER_STATUS(pwr), .FAULT_STATUS(flt), .CC_STATUS(cc), .TX_BUFFER_FLUSH(),
    .RX_OVERFLOW_ACTIVE(ovf), .ALERT_N(alert_n));
  pdam_host_model u_pdam_host_model(.clk(clk), .req(req), .rdata(rdata));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_pdam_host_model.rd(a, d);
    chk(d, e);
  endtask
  task automatic pulse(input pdam_event_s e);
    @(negedge clk);
    ev = e;
    @(negedge clk);
    ev = '0;
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_reset();
    logic [7:0] ex [7] = '{8'h00, 8'h00, 8'hff, 8'h8f, 8'hff, 8'h33, 8'h00};
    for (int i = 0; i < 7; i++) rc(8'(16 + i), ex[i]);
    $display("reset values done");
  endtask
  // struct bit 9 is vbus_high_alarm, bit 0 rx_overflow
  task automatic t_events();
    logic [7:0] bm [10] = '{8'h04, 8'h08, 8'h80, 8'h01, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
    logic [7:0] a;
    for (int i = 9; i >= 0; i--) begin
      a = (i > 3) ? 8'h10 : 8'h11;
      pulse(pdam_event_s'(10'h1 << i));
      rc(a, bm[i]);
      chk({7'h0, alert_n}, 8'h00);
      u_pdam_host_model.wr(a, ~bm[i]);
      rc(a, bm[i]);
      u_pdam_host_model.wr(a, bm[i]);
      rc(a, 8'h00);
      chk({7'h0, alert_n}, 8'h01);
    end
    chk({7'h0, ovf}, 8'h01);
    u_pdam_host_model.wr(8'h10, 8'h04);
    // overflow output lags the clear by one more edge
    @(negedge clk);
    chk({7'h0, ovf}, 8'h00);
    bcz = 1'b1;
    pulse(pdam_event_s'(10'h010));
    bcz = 1'b0;
    rc(8'h10, 8'h00);
    cc = 8'h5a;
    rc(8'h10, 8'h01);
    u_pdam_host_model.wr(8'h10, 8'h01);
    $display("events done");
  endtask
  task automatic t_mask();
    u_pdam_host_model.wr(8'h12, 8'h7f);
    pulse(pdam_event_s'(10'h200));
    rc(8'h10, 8'h80);
    chk({7'h0, alert_n}, 8'h01);
    u_pdam_host_model.wr(8'h12, 8'hff);
    @(negedge clk);
    chk({7'h0, alert_n}, 8'h00);
    u_pdam_host_model.wr(8'h10, 8'h80);
    u_pdam_host_model.wr(8'h13, 8'hff);
    rc(8'h13, 8'h8f);
    u_pdam_host_model.wr(8'h14, 8'h00);
    u_pdam_host_model.wr(8'h15, 8'hff);
    rc(8'h15, 8'hb3);
    @(negedge clk);
    swr = 1'b1;
    @(negedge clk);
    swr = 1'b0;
    rc(8'h15, 8'h33);
    rc(8'h14, 8'hff);
    // a received hard reset reloads the masks as well
    u_pdam_host_model.wr(8'h12, 8'h00);
    pulse(pdam_event_s'(10'h020));
    rc(8'h12, 8'hff);
    rc(8'h10, 8'h08);
    u_pdam_host_model.wr(8'h10, 8'h08);
    rc(8'h10, 8'h00);
    $display("mask done");
  endtask
  // level causes re-set the flag, so the mask must drop before a clear sticks
  task automatic t_summary();
    pwr = 8'h01;
    rc(8'h10, 8'h02);
    u_pdam_host_model.wr(8'h14, 8'hfe);
    u_pdam_host_model.wr(8'h10, 8'h02);
    rc(8'h10, 8'h00);
    flt = 8'h04;
    rc(8'h11, 8'h00);
    flt = 8'h01;
    rc(8'h11, 8'h02);
    $display("summary done");
  endtask
  initial begin
    ev = '0;
    pwr = '0;
    flt = '0;
    cc = '0;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_events();
    t_mask();
    t_summary();
    close_out();
  end
  initial begin
    repeat (4000) @(posedge clk);
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire
